// ---- hw/lmc_core.sv ----
// Purpose: mode control and supervision of a subscriber line interface
// Assumes: mode pins, tone, thermal, ring trip and clock straps are async pins;
//          hook_current_ma comes from a sampler already on aclk
// Notes:   registers over AXI4-Lite; detect pin is open drain
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module lmc_core
  import lmc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned CUR_W  = 4,
  parameter int unsigned RAMP_W = 6
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              supply_on_sel,
  input  wire logic              mode_sel_lo,
  input  wire logic              mode_sel_hi,
  input  wire logic              polarity_ctl,
  input  wire logic              meter_tone_clock,
  input  wire logic              temp_over_limit,
  input  wire logic              temp_below_hyst,
  input  wire logic              ring_trip_seen,
  input  wire logic              conv_clk_ext,
  input  wire logic              conv_clk_tied_vcc,
  input  wire logic              conv_clk_tied_gnd,
  input  wire logic [CUR_W-1:0]  hook_current_ma,
  output logic                   loop_detect_n_o,
  output logic                   loop_detect_n_oe,
  output logic                   line_drv_en,
  output logic                   line_hiz,
  output logic                   detectors_en,
  output logic                   dc_feed_en,
  output logic                   ac_tx_en,
  output logic                   meter_inject_en,
  output logic                   meter_tone_out,
  output logic                   battery_high_sel,
  output logic                   gain_high_sel,
  output logic                   polarity_rev,
  output logic [RAMP_W-1:0]      reversal_ramp,
  output logic                   conv_gate
);
  localparam int unsigned NSYNC = 11;
  localparam int unsigned HALF_W = $clog2(CONV_HALF_CYC);
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(CONV_HALF_CYC - 1);

  // decode of the pin settings into an operating mode
  function automatic lmc_mode_t decode_mode(input logic pwr, input logic lo,
                                            input logic hi);
    unique case ({lo, hi})
      2'b00:   decode_mode = pwr ? MODE_HIZ : MODE_DOWN;
      2'b01:   decode_mode = MODE_ACT;
      2'b11:   decode_mode = MODE_ACT_TTX;
      2'b10:   decode_mode = MODE_RING;
    endcase
  endfunction : decode_mode

  // keep a programmed threshold within the documented range
  function automatic logic [3:0] clamp_thr(input logic [3:0] v);
    if (v < HOOK_MIN_MA) begin
      clamp_thr = HOOK_MIN_MA;
    end else if (v > HOOK_MAX_MA) begin
      clamp_thr = HOOK_MAX_MA;
    end else begin
      clamp_thr = v;
    end
  endfunction : clamp_thr

  logic [NSYNC-1:0]      sync1_reg;
  logic [NSYNC-1:0]      sync2_reg;
  logic                  pwr_s, lo_s, hi_s, pol_s, tone_s, over_s, cool_s;
  logic                  trip_s, ext_s, vcc_s, gnd_s;
  logic                  hot_reg;
  lmc_mode_t             mode_reg;
  lmc_mode_t             mode_next;
  logic                  gain_reg;
  logic [3:0]            thr_reg;
  logic [RAMP_DIV_W-1:0] ramp_div_reg;
  logic                  loop_ind_reg, loop_ind_next;
  logic                  drv_reg, hiz_reg, detn_reg, dc_reg, ac_reg;
  logic                  ttx_reg, tone_reg, bat_reg, gain_out_reg, rev_reg;
  logic                  is_active, is_live, hook_s, rev_next;
  logic [HALF_W-1:0]     osc_cnt_reg;
  logic                  osc_reg;
  logic                  gate_reg, gate_next;
  logic                  ramp_busy;
  logic                  aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0]     awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic [1:0]            bresp_reg, rresp_reg;
  logic [31:0]           rdata_reg, rd_mux;
  logic                  do_write, do_read, wr_ctrl, wr_ramp, rd_hit, wr_hit;

  // two-flop synchronisers for every pin input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {supply_on_sel, mode_sel_lo, mode_sel_hi, polarity_ctl,
                    meter_tone_clock, temp_over_limit, temp_below_hyst,
                    ring_trip_seen, conv_clk_ext, conv_clk_tied_vcc,
                    conv_clk_tied_gnd};
      sync2_reg <= sync1_reg;
    end
  end
  assign {pwr_s, lo_s, hi_s, pol_s, tone_s, over_s, cool_s, trip_s, ext_s, vcc_s,
          gnd_s} = sync2_reg;

  // mode selection, thermal override wins over the pins
  assign mode_next = hot_reg ? MODE_DOWN : decode_mode(pwr_s, lo_s, hi_s);
  assign is_active = (mode_reg == MODE_ACT) || (mode_reg == MODE_ACT_TTX);
  assign is_live   = is_active || (mode_reg == MODE_HIZ);
  assign hook_s    = (hook_current_ma >= CUR_W'(thr_reg));
  assign loop_ind_next = (is_live && hook_s)
                       || ((mode_reg == MODE_RING) && trip_s);
  assign rev_next  = (is_active || (mode_reg == MODE_RING)) && pol_s;

  // thermal flag: set wins, cleared only when cooled below hysteresis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hot_reg  <= 1'b0;
      mode_reg <= MODE_DOWN;
    end else begin
      hot_reg  <= over_s || (hot_reg && !cool_s);
      mode_reg <= mode_next;
    end
  end

  // registered line control outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_ind_reg <= 1'b0;
      drv_reg      <= 1'b0;
      hiz_reg      <= 1'b1;
      detn_reg     <= 1'b0;
      dc_reg       <= 1'b0;
      ac_reg       <= 1'b0;
      ttx_reg      <= 1'b0;
      tone_reg     <= 1'b0;
      bat_reg      <= 1'b0;
      gain_out_reg <= 1'b0;
      rev_reg      <= 1'b0;
    end else begin
      loop_ind_reg <= loop_ind_next;
      drv_reg      <= (mode_reg != MODE_DOWN);
      hiz_reg      <= (mode_reg == MODE_DOWN);
      detn_reg     <= (mode_reg != MODE_DOWN);
      dc_reg       <= is_live;
      ac_reg       <= is_active;
      ttx_reg      <= (mode_reg == MODE_ACT_TTX);
      tone_reg     <= (mode_reg == MODE_ACT_TTX) && tone_s;
      bat_reg      <= (mode_reg == MODE_RING);
      gain_out_reg <= is_active && gain_reg;
      rev_reg      <= rev_next;
    end
  end

  // open-drain detect: output value is low, enable marks the active state
  assign loop_detect_n_o  = 1'b0;
  assign loop_detect_n_oe = loop_ind_reg;
  assign line_drv_en      = drv_reg;
  assign line_hiz         = hiz_reg;
  assign detectors_en     = detn_reg;
  assign dc_feed_en       = dc_reg;
  assign ac_tx_en         = ac_reg;
  assign meter_inject_en  = ttx_reg;
  assign meter_tone_out   = tone_reg;
  assign battery_high_sel = bat_reg;
  assign gain_high_sel    = gain_out_reg;
  assign polarity_rev     = rev_reg;

  // soft reversal ramp toward the requested polarity
  lmc_ramp #(.RAMP_W(RAMP_W)) u_ramp (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .target_rev (rev_reg),
    .step_div   (ramp_div_reg),
    .pos        (reversal_ramp),
    .busy       (ramp_busy)
  );

  // internal converter oscillator and switch drive selection
  assign gate_next = gnd_s ? 1'b0 : (vcc_s ? osc_reg : ext_s);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_reg <= '0;
      osc_reg     <= 1'b0;
      gate_reg    <= 1'b0;
    end else begin
      osc_cnt_reg <= (osc_cnt_reg == HALF_LAST) ? '0 : osc_cnt_reg + 1'b1;
      osc_reg     <= (osc_cnt_reg == HALF_LAST) ? !osc_reg : osc_reg;
      gate_reg    <= gate_next;
    end
  end
  assign conv_gate = gate_reg;

  // bus decode
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign do_read  = s_axi_arvalid && !rvalid_reg;
  assign wr_ctrl  = do_write && (awaddr_reg == ADDR_W'(CTRL_OFS));
  assign wr_ramp  = do_write && (awaddr_reg == ADDR_W'(RAMP_OFS));
  assign wr_hit   = wr_ctrl || wr_ramp || (awaddr_reg == ADDR_W'(STAT_OFS));
  assign rd_hit   = (s_axi_araddr == ADDR_W'(CTRL_OFS))
                 || (s_axi_araddr == ADDR_W'(STAT_OFS))
                 || (s_axi_araddr == ADDR_W'(RAMP_OFS));

  // read data selection
  always_comb begin
    rd_mux = RD_ZERO;
    if (s_axi_araddr == ADDR_W'(CTRL_OFS)) begin
      rd_mux[CTRL_GAIN_BIT] = gain_reg;
      rd_mux[CTRL_THR_LSB +: THR_W] = thr_reg;
    end else if (s_axi_araddr == ADDR_W'(STAT_OFS)) begin
      rd_mux[STAT_MODE_LSB +: 3] = mode_reg;
      rd_mux[STAT_HOT_BIT]       = hot_reg;
      rd_mux[STAT_LOOP_BIT]      = loop_ind_reg;
      rd_mux[STAT_REV_BIT]       = rev_reg;
      rd_mux[STAT_BUSY_BIT]      = ramp_busy;
    end else if (s_axi_araddr == ADDR_W'(RAMP_OFS)) begin
      rd_mux[RAMP_DIV_W-1:0] = ramp_div_reg;
    end
  end

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_reg     <= GAIN_RST;
      thr_reg      <= THR_RST;
      ramp_div_reg <= RAMP_DIV_RST;
    end else begin
      if (wr_ctrl && wstrb_reg[0]) begin
        gain_reg <= wdata_reg[CTRL_GAIN_BIT];
        thr_reg  <= clamp_thr(wdata_reg[CTRL_THR_LSB +: THR_W]);
      end
      if (wr_ramp && wstrb_reg[0]) begin
        ramp_div_reg[7:0] <= wdata_reg[7:0];
      end
      if (wr_ramp && wstrb_reg[1]) begin
        ramp_div_reg[15:8] <= wdata_reg[15:8];
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= RD_ZERO;
      rresp_reg  <= RESP_OKAY;
    end else if (do_read) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence hot_seen_s;
    over_s ##1 hot_reg;
  endsequence

  // thermal overload reaches power down two edges after the sync output
  thermal_down_a: assert property (hot_seen_s |=> mode_reg == MODE_DOWN)
    else $error("overheat did not force power down");
  thermal_hold_a: assert property (hot_reg && !cool_s |=> hot_reg)
    else $error("thermal flag dropped before cooling");
  down_drivers_a: assert property ((mode_reg == MODE_DOWN) |=>
    !line_drv_en && line_hiz && !detectors_en && !loop_detect_n_oe)
    else $error("power down left line active");
  ac_active_a: assert property (ac_tx_en |-> $past(is_active))
    else $error("transmission outside active mode");
  hiz_detect_a: assert property ((mode_reg == MODE_HIZ) && hook_s |=>
    loop_detect_n_oe && !loop_detect_n_o)
    else $error("off-hook in high impedance not reported");
  ring_trip_a: assert property ((mode_reg == MODE_RING) && trip_s |=> loop_detect_n_oe)
    else $error("ring trip not reported");
  ring_battery_a: assert property ((mode_reg == MODE_RING) |=> battery_high_sel)
    else $error("ringing without raised battery");
  gate_off_a: assert property (gnd_s |=> !conv_gate)
    else $error("switch drive active with ground strap");
  meter_mode_a: assert property (meter_inject_en |-> $past(mode_reg == MODE_ACT_TTX))
    else $error("metering outside metering mode");
  gain_sel_a: assert property (is_active && gain_reg |=> gain_high_sel)
    else $error("gain select not applied");
endmodule : lmc_core

// ---- hw/lmc_pkg.sv ----
// Purpose: shared constants and types for the line mode control block
// Assumes: 10 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   register offsets are byte addresses
package lmc_pkg;
  // timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CONV_CLK_HZ   = 125_000;
  localparam int unsigned CONV_HALF_CYC = CLK_HZ / (2 * CONV_CLK_HZ);
  // register map
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam logic [7:0]  RAMP_OFS      = 8'h08;
  // control fields
  localparam int unsigned CTRL_GAIN_BIT = 0;
  localparam int unsigned CTRL_THR_LSB  = 4;
  localparam int unsigned THR_W         = 4;
  localparam logic        GAIN_RST      = 1'h0;
  localparam logic [3:0]  THR_RST       = 4'h7;
  localparam logic [3:0]  HOOK_MIN_MA   = 4'h5;
  localparam logic [3:0]  HOOK_MAX_MA   = 4'h9;
  // ramp step divider
  localparam int unsigned RAMP_DIV_W    = 16;
  localparam logic [15:0] RAMP_DIV_RST  = 16'h0064;
  // status fields
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_HOT_BIT  = 4;
  localparam int unsigned STAT_LOOP_BIT = 5;
  localparam int unsigned STAT_REV_BIT  = 6;
  localparam int unsigned STAT_BUSY_BIT = 7;
  // bus answers
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

  typedef enum logic [2:0] {
    MODE_DOWN,
    MODE_HIZ,
    MODE_ACT,
    MODE_ACT_TTX,
    MODE_RING
  } lmc_mode_t;
endpackage : lmc_pkg

// ---- hw/lmc_ramp.sv ----
// Purpose: soft polarity reversal ramp position generator
// Assumes: step_div plus one is the number of aclk cycles between ramp steps
// Notes:   position 0 is normal polarity, all ones is reverse
`timescale 1ns/1ps
module lmc_ramp
  import lmc_pkg::*;
#(
  parameter int unsigned RAMP_W = 6
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  target_rev,
  input  wire logic [RAMP_DIV_W-1:0] step_div,
  output logic      [RAMP_W-1:0]     pos,
  output logic                       busy
);
  localparam logic [RAMP_W-1:0] POS_MAX = {RAMP_W{1'b1}};

  logic [RAMP_W-1:0]     pos_reg;
  logic [RAMP_W-1:0]     pos_next;
  logic [RAMP_DIV_W-1:0] div_reg;
  logic [RAMP_DIV_W-1:0] div_next;
  logic                  at_goal;
  logic                  tick;

  // one step toward the goal per divider expiry
  assign at_goal  = target_rev ? (pos_reg == POS_MAX) : (pos_reg == '0);
  assign tick     = (div_reg == '0);
  assign div_next = (tick || at_goal) ? step_div : div_reg - 1'b1;
  assign pos_next = (!tick || at_goal) ? pos_reg
                  : (target_rev ? pos_reg + 1'b1 : pos_reg - 1'b1);
  assign pos      = pos_reg;
  assign busy     = !at_goal;

  // ramp state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_reg <= '0;
      div_reg <= '0;
    end else begin
      pos_reg <= pos_next;
      div_reg <= div_next;
    end
  end

  // never jumps more than one step per cycle
  ramp_step_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(pos_reg) |-> (pos_reg == $past(pos_reg) + 1'b1)
                       || (pos_reg == $past(pos_reg) - 1'b1))
    else $error("ramp position jumped");
endmodule : lmc_ramp

// ---- verification/lmc_ctl_model.sv ----
// Purpose: line card controller model facing the mode pins
// Assumes: cmd holds supply select, low selector, high selector, polarity
// Notes:   tone and ring toggles share one half-period counter
`timescale 1ns/1ps
module lmc_ctl_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] cmd,
  input  wire logic       ring_en,
  input  wire logic       loop_pin_n,
  output logic            supply_on_sel,
  output logic            mode_sel_lo,
  output logic            mode_sel_hi,
  output logic            polarity_ctl,
  output logic            meter_tone_clock,
  output logic            loop_sync_n
);
  logic [1:0] ind_ff;
  logic [8:0] cnt;
  logic       wrap;
  // roughly 12 kHz half period at 10 MHz
  assign wrap       = (cnt == 9'h1a0);
  assign loop_sync_n = ind_ff[1];
  // detect pin is async to us: two flops before use
  always_ff @(posedge aclk) ind_ff <= {ind_ff[0], loop_pin_n};
  // selectors move on one edge; ringing stops once detect is seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 9'h000;
      meter_tone_clock <= 1'h0;
      {supply_on_sel, mode_sel_lo, mode_sel_hi, polarity_ctl} <= 4'h0;
    end else begin
      cnt <= wrap ? 9'h000 : cnt + 9'h001;
      if (wrap) meter_tone_clock <= ~meter_tone_clock;
      {supply_on_sel, mode_sel_lo, mode_sel_hi} <= cmd[3:1];
      if (!ring_en) polarity_ctl <= cmd[0];
      else if (wrap && loop_sync_n) polarity_ctl <= ~polarity_ctl;
    end
  end
endmodule : lmc_ctl_model

// ---- verification/tb_lmc_core.sv ----
// Purpose: self-checking bench for the line mode control core
// Assumes: controller model drives the mode pins and tone clock, bench drives the rest
// Notes:   ramp divider set to 1 so reversals settle quickly
`timescale 1ns/1ps
module tb_lmc_core;
  import lmc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, supply_on_sel, mode_sel_lo, mode_sel_hi, polarity_ctl;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, cmd, hook_current_ma;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic meter_tone_clock, temp_over_limit, temp_below_hyst, ring_trip_seen;
  logic conv_clk_ext, conv_clk_tied_vcc, conv_clk_tied_gnd, ring_en, ext_on;
  logic loop_detect_n_o, loop_detect_n_oe, loop_pin_n, loop_sync_n, line_drv_en;
  logic line_hiz, detectors_en, dc_feed_en, ac_tx_en, meter_inject_en;
  logic meter_tone_out, battery_high_sel, gain_high_sel, polarity_rev, conv_gate;
  logic [5:0]  reversal_ramp;
  logic [2:0]  tone_d;
  logic [19:0] rows [9];
  int          error_cnt, total_checks, ncyc, gate_n, pol_n;

  lmc_core i_lmc_core (.*);
  lmc_ctl_model i_lmc_ctl_model (.*);
  // open-drain detect wire with pull-up
  assign loop_pin_n = loop_detect_n_oe ? loop_detect_n_o : 1'h1;
  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  // external converter clock, 125 kHz, and edge counters
  always @(posedge aclk) begin
    ncyc <= ncyc + 1;
    tone_d <= {tone_d[1:0], meter_tone_clock}; // tone pin as seen three flops later
    if (ext_on && ncyc % 40 == 0) conv_clk_ext <= ~conv_clk_ext;
  end
  always @(posedge conv_gate) gate_n++;
  always @(polarity_ctl) pol_n++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic tmo(input string nm);
    error_cnt++;
    $display("unexpected %s: no answer", nm);
    finish_test();
  endtask : tmo
  task automatic ticks(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : ticks
  // one write: address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, done;
    int   n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    done = 1'h0;
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      done = s_axi_bvalid;
      if (done) chk(s_axi_bresp, er, "bresp");
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    if (!done) tmo("write");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    logic ta, done;
    int   n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    done = 1'h0;
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      done = s_axi_rvalid;
      if (done) chk(s_axi_rdata, ev, "rdata");
      if (done) chk(s_axi_rresp, er, "rresp");
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    if (!done) tmo("read");
  endtask : rd
  // row: pins, line current, mode, then ac/meter/battery/reverse/detect
  task automatic run_row(input logic [19:0] r);
    logic [2:0] m;
    logic [4:0] f;
    m = r[10:8];
    f = r[4:0];
    cmd <= r[19:16];
    hook_current_ma <= r[15:12];
    ticks(200);
    chk(ac_tx_en, f[4], "ac_tx");
    chk(dc_feed_en, f[4] || m == 3'h1, "dc_feed");
    chk(meter_inject_en, f[3], "meter");
    chk(meter_tone_out, f[3] & tone_d[2], "tone");
    chk(battery_high_sel, f[2], "battery");
    chk(polarity_rev, f[1], "polarity");
    chk(reversal_ramp, {6{f[1]}}, "ramp");
    chk(loop_pin_n, !f[0], "detect");
    chk({line_drv_en, detectors_en}, {2{m != 3'h0}}, "drivers");
    rd(STAT_OFS, {25'h0, f[1], f[0], 2'h0, m}, RESP_OKAY);
  endtask : run_row

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
    {s_axi_rready, temp_over_limit, temp_below_hyst, ring_trip_seen} = 4'h0;
    {conv_clk_ext, conv_clk_tied_vcc, conv_clk_tied_gnd, ring_en} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {cmd, hook_current_ma} = 8'h00;
    s_axi_wstrb = 4'hf;
    ext_on = 1'h1;
    {error_cnt, total_checks, ncyc, gate_n, pol_n} = '0;
    rows = '{20'h0_8000, 20'h1_8000, 20'h8_8101, 20'h9_6100, 20'hA_8211,
             20'hB_6212, 20'hE_7319, 20'hF_031A, 20'hC_8404};
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    ticks(0);
    chk(line_hiz, 1'h1, "line_hiz");
    rd(CTRL_OFS, 32'h0000_0070, RESP_OKAY);
    rd(RAMP_OFS, 32'h0000_0064, RESP_OKAY);
    wr(8'h0c, 32'h0000_0001, RESP_SLVERR);
    rd(8'h0c, RD_ZERO, RESP_SLVERR);
    wr(STAT_OFS, 32'hffff_ffff, RESP_OKAY);
    wr(RAMP_OFS, 32'h0000_0001, RESP_OKAY);
    foreach (rows[i]) run_row(rows[i]);
    // gain set only in active modes
    run_row(20'hA_0210);
    wr(CTRL_OFS, 32'h0000_0071, RESP_OKAY);
    ticks(8);
    chk(gain_high_sel, 1'h1, "gain");
    cmd <= 4'h8;
    ticks(8);
    chk(gain_high_sel, 1'h0, "gain");
    // threshold clamps, shared by high-impedance and active feed
    wr(CTRL_OFS, 32'h0000_0030, RESP_OKAY);
    rd(CTRL_OFS, 32'h0000_0050, RESP_OKAY);
    run_row(20'h8_5101);
    run_row(20'hA_5211);
    run_row(20'h8_4100);
    wr(CTRL_OFS, 32'h0000_00f0, RESP_OKAY);
    rd(CTRL_OFS, 32'h0000_0090, RESP_OKAY);
    run_row(20'hA_8210);
    run_row(20'hA_9211);
    // overheating forces power down, cooling restores active
    run_row(20'hA_0210);
    temp_over_limit <= 1'h1;
    ticks(10);
    chk({line_hiz, ac_tx_en, line_drv_en}, 3'h4, "hot line");
    rd(STAT_OFS, 32'h0000_0010, RESP_OKAY);
    temp_over_limit <= 1'h0;
    temp_below_hyst <= 1'h1;
    ticks(10);
    rd(STAT_OFS, 32'h0000_0002, RESP_OKAY);
    temp_below_hyst <= 1'h0;
    // ringing, ring trip, controller stops toggling
    cmd <= 4'hc;
    ring_en <= 1'h1;
    pol_n = 0;
    ticks(2000);
    chk(pol_n > 0, 1'h1, "ring toggles");
    ring_trip_seen <= 1'h1;
    ticks(10);
    chk(loop_pin_n, 1'h0, "ring trip");
    pol_n = 0;
    ticks(1000);
    chk(pol_n, 0, "toggle stop");
    {ring_en, ring_trip_seen} <= 2'h0;
    cmd <= 4'ha;
    // converter clock sources and ground strap
    gate_n = 0;
    ticks(400);
    chk(gate_n > 0, 1'h1, "ext gate");
    conv_clk_tied_gnd <= 1'h1;
    ticks(5);
    gate_n = 0;
    ticks(400);
    chk(gate_n, 0, "gnd gate");
    {conv_clk_tied_gnd, conv_clk_tied_vcc, ext_on} <= 3'h2;
    ticks(5);
    gate_n = 0;
    ticks(400);
    chk(gate_n > 0, 1'h1, "int gate");
    finish_test();
  end
endmodule : tb_lmc_core
